// ### rtl/fprs_map.svh
// Register offsets, field positions, reset values and timing figures of the reset supervisor.
`ifndef FPRS_MAP_SVH
`define FPRS_MAP_SVH
`define FPRS_CLK_HZ 200000000
`define FPRS_RST_DEB_MS 50
`define FPRS_FP_DEB_MS 8
`define FPRS_PRESS_MS 100
`define FPRS_BLINK_HALF_MS 500
`define FPRS_POST_HOLD_MS 1
`define FPRS_ADDR_CTRL 8'h00
`define FPRS_ADDR_STATUS 8'h04
`define FPRS_ADDR_EVENT 8'h08
`define FPRS_ADDR_REASON 8'h0C
`define FPRS_ADDR_POST 8'h10
`define FPRS_CTRL_LOCK 0
`define FPRS_CTRL_CMD_RST 1
`define FPRS_CTRL_LOG_EN 2
`define FPRS_CTRL_ACT_RST 3
`define FPRS_CTRL_PEF_EN 4
`define FPRS_CTRL_USE_LSB 5
`define FPRS_CTRL_PEF_ACT 8
`define FPRS_CTRL_WMASK 8'hFD
`define FPRS_CTRL_RST 8'h00
`define FPRS_USE_BOOT_FAIL 3'h1
`define FPRS_RSN_BOOT 0
`define FPRS_RSN_OTHER 1
`define FPRS_PIN_IDLE 6'h1F
`define FPRS_INTR_OFFSET 8'h00
`define FPRS_FAN_BOOST 8'hFF
`define FPRS_FIFO_DEPTH 8
`endif

// ### rtl/fprs_pkg.sv
// Types shared by the reset supervisor.
package fprs_pkg;
	typedef enum logic [2:0] {LED_OFF, LED_OK, LED_DEGRADED, LED_NONFATAL, LED_FATAL} fprs_led_t;
	typedef enum logic [1:0] {INTR_NORMAL, INTR_ACTIVE, INTR_INIT} fprs_intr_t;
	typedef enum logic {PRESS_IDLE, PRESS_ON} fprs_press_t;
	typedef struct packed {
		logic fatal;
		logic nonfatal;
		logic degraded;
		logic ready;
	} fprs_fault_t;
	typedef struct packed {
		logic sec_violation;
		logic intrusion;
		logic cable_missing;
		logic wdog_boot_fail;
		logic host_reset;
	} fprs_evt_t;
endpackage

// ### rtl/fprs_supervisor.sv
// Front panel and system reset supervisor with POST code capture.
// Contract
// - Reset button state change recognised only after 50 ms of stable input.
// - Locked reset button press raises a security violation event, no reset.
// - System reset is an emulated button press; chipset finishes it alone.
// - POST-complete de-assertion means a host reset occurred; no participation.
// - Every detected system reset starts the sensor initialisation agent.
// - Power-up, button, soft, hard, command, watchdog reset; PEF optionally.
// - Own reset on standby power-up and firmware update, not own watchdog.
// - After own reset, adopt current power and processor signal states.
// - Boot-failure watchdog expiry logs if enabled, then resets if selected.
// - Timeout-reason bits survive host resets, cleared only by AC loss; the code also clears them by a write to the reason register.
// - Boot-failure watchdog expiry leaves front panel LEDs unchanged.
// - From standby, port 80h writes go into a FIFO shown on POST LEDs.
// - No flow control on port 80h; overflow drops oldest codes.
// - Status LED shows most severe fault; amber overrides green.
// - Green solid, green blink, amber blink, amber solid, off by severity.
// - Across DC-off or soft-off, sensor and LED states are retained.
// - Front panel inputs asserted only after 8 ms of constant level.
// - Each intrusion change yields a security event with offset 00h.
// - Intrusion boosts all fans; clearing restores previous levels.
// - Missing intrusion cable logs an event and sets init-in-progress.
// - Intrusion detected and logged in on, sleep and standby states.
// - Lockout set by command and readable in the status.
// - Power button asserted only after 8 ms of constant state.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fprs_map.svh"
module fprs_supervisor #(
	parameter int CLK_HZ        = `FPRS_CLK_HZ,
	parameter int RST_DEB_CYC   = CLK_HZ / 1000 * `FPRS_RST_DEB_MS,
	parameter int FP_DEB_CYC    = CLK_HZ / 1000 * `FPRS_FP_DEB_MS,
	parameter int PRESS_CYC     = CLK_HZ / 1000 * `FPRS_PRESS_MS,
	parameter int BLINK_CYC     = CLK_HZ / 1000 * `FPRS_BLINK_HALF_MS,
	parameter int POST_HOLD_CYC = CLK_HZ / 1000 * `FPRS_POST_HOLD_MS
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	input  wire logic                 reset_btn_n,
	input  wire logic                 power_btn_n,
	input  wire logic                 intrusion_n,
	input  wire logic                 intr_cable_ok,
	input  wire logic                 post_complete_n,
	input  wire logic                 main_pwr_good,
	input  wire logic                 fw_update_done,
	input  wire logic                 wdog_expire,
	input  wire logic                 port80_wr,
	input  wire logic [7:0]           port80_data,
	input  wire fprs_pkg::fprs_fault_t faults,
	input  wire logic [7:0]           fan_level_in,
	output logic                      chipset_rst_n,
	output logic                      led_green,
	output logic                      led_amber,
	output logic [7:0]                fan_level_out,
	output logic [7:0]                post_led,
	output fprs_pkg::fprs_evt_t       events,
	output logic [7:0]                evt_offset,
	output logic                      sia_start
);
	localparam int DEPTH = `FPRS_FIFO_DEPTH;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [26:0] deb_last(input int idx);
		deb_last = (idx == 0) ? 27'(RST_DEB_CYC - 1) : 27'(FP_DEB_CYC - 1);
	endfunction

	// Firmware update completion resets the core but not the timeout-reason bits.
	logic blk_rst;
	wire  core_rst = sys_rst | blk_rst;

	logic [5:0]  pin_s1;
	logic [5:0]  pin_s2;
	logic [3:0]  deb;
	logic [3:0]  deb_prev;
	logic [26:0] deb_cnt [4];
	logic [1:0]  init_cnt;
	logic        prev_post;
	logic        prev_pg;

	wire [5:0] pin_raw = {main_pwr_good, post_complete_n, intr_cable_ok,
		intrusion_n, power_btn_n, reset_btn_n};
	wire armed  = (init_cnt == 2'h3);
	wire post_s = pin_s2[4];
	wire pg_s   = pin_s2[5];

	always_ff @(posedge clk) begin
		blk_rst <= sys_rst ? 1'b0 : fw_update_done;
	end

	always_ff @(posedge clk) begin
		if (core_rst) begin
			pin_s1 <= `FPRS_PIN_IDLE;
			pin_s2 <= `FPRS_PIN_IDLE;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	// Edges are only judged once the synchronisers hold real pin levels.
	always_ff @(posedge clk) begin
		if (core_rst) begin
			init_cnt <= 2'h0;
		end else if (!armed) begin
			init_cnt <= init_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		prev_post <= post_s;
		prev_pg   <= pg_s;
	end

	always_ff @(posedge clk) begin
		if (core_rst) begin
			deb      <= 4'hF;
			deb_prev <= 4'hF;
			for (int i = 0; i < 4; i++) begin
				deb_cnt[i] <= 27'h000_0000;
			end
		end else begin
			deb_prev <= deb;
			for (int i = 0; i < 4; i++) begin
				if (pin_s2[i] == deb[i]) begin
					deb_cnt[i] <= 27'h000_0000;
				end else if (deb_cnt[i] == deb_last(i)) begin
					deb[i]     <= pin_s2[i];
					deb_cnt[i] <= 27'h000_0000;
				end else begin
					deb_cnt[i] <= deb_cnt[i] + 27'h000_0001;
				end
			end
		end
	end

	wire rst_press  = armed & deb_prev[0] & ~deb[0];
	wire intr_chg   = armed & (deb_prev[2] ^ deb[2]);
	wire cable_lost = armed & deb_prev[3] & ~deb[3];
	wire post_rise  = armed & ~prev_post & post_s;
	wire pg_rise    = armed & ~prev_pg & pg_s;

	logic [7:0] ctrl;
	logic [4:0] evt_flags;
	logic [1:0] reason;

	wire wr_ctrl   = reg_wr & hit(reg_addr, `FPRS_ADDR_CTRL);
	wire wr_event  = reg_wr & hit(reg_addr, `FPRS_ADDR_EVENT);
	wire wr_reason = reg_wr & hit(reg_addr, `FPRS_ADDR_REASON);
	wire lock      = ctrl[`FPRS_CTRL_LOCK];
	wire cmd_rst   = wr_ctrl & reg_wdata[`FPRS_CTRL_CMD_RST];
	wire pef_rst   = wr_ctrl & reg_wdata[`FPRS_CTRL_PEF_ACT] & ctrl[`FPRS_CTRL_PEF_EN];
	wire [2:0] use_field = ctrl[`FPRS_CTRL_USE_LSB +: 3];
	wire boot_use  = (use_field == `FPRS_USE_BOOT_FAIL);
	wire wdog_log  = wdog_expire & boot_use & ctrl[`FPRS_CTRL_LOG_EN];
	wire wdog_rst  = wdog_expire & ctrl[`FPRS_CTRL_ACT_RST];
	wire rsn_clr   = wr_reason & reg_wdata[`FPRS_RSN_BOOT];

	always_ff @(posedge clk) begin
		if (core_rst) begin
			ctrl <= `FPRS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata[7:0] & `FPRS_CTRL_WMASK;
		end
	end

	// Timeout reasons see only the standby power reset, so host resets keep them.
	wire [1:0] rsn_set = {wdog_expire & ~boot_use, wdog_expire & boot_use};
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reason <= 2'h0;
		end else begin
			reason <= (reason & ~(reg_wdata[1:0] & {2{wr_reason}})) | rsn_set;
		end
	end

	wire [4:0] evt_set = {armed & rst_press & lock, intr_chg, cable_lost, wdog_log,
		post_rise | pg_rise};
	always_ff @(posedge clk) begin
		if (core_rst) begin
			evt_flags <= 5'h00;
			events    <= '0;
			sia_start <= 1'b0;
		end else begin
			// A new event in the clearing cycle survives the clear.
			evt_flags <= (evt_flags & ~(reg_wdata[4:0] & {5{wr_event}})) | evt_set;
			events    <= fprs_pkg::fprs_evt_t'(evt_set);
			sia_start <= post_rise | pg_rise;
		end
	end

	always_ff @(posedge clk) begin
		if (core_rst) begin
			evt_offset <= `FPRS_INTR_OFFSET;
		end else if (intr_chg) begin
			evt_offset <= `FPRS_INTR_OFFSET;
		end
	end

	fprs_pkg::fprs_press_t press_st;
	logic [26:0] press_cnt;
	wire press_req = (rst_press & ~lock) | cmd_rst | wdog_rst | pef_rst;
	wire press_go  = armed & press_req & (press_st == fprs_pkg::PRESS_IDLE);
	wire press_end = (press_cnt == 27'(PRESS_CYC - 1));

	// The press is a fixed pulse; the chipset runs the rest of the reset.
	always_ff @(posedge clk) begin
		if (core_rst) begin
			press_st      <= fprs_pkg::PRESS_IDLE;
			press_cnt     <= 27'h000_0000;
			chipset_rst_n <= 1'b1;
		end else begin
			unique case (press_st)
				fprs_pkg::PRESS_IDLE: begin
					if (press_go) begin
						press_st      <= fprs_pkg::PRESS_ON;
						chipset_rst_n <= 1'b0;
					end
				end
				fprs_pkg::PRESS_ON: begin
					if (press_end) begin
						press_st      <= fprs_pkg::PRESS_IDLE;
						press_cnt     <= 27'h000_0000;
						chipset_rst_n <= 1'b1;
					end else begin
						press_cnt <= press_cnt + 27'h000_0001;
					end
				end
			endcase
		end
	end

	fprs_pkg::fprs_intr_t intr_st;
	fprs_pkg::fprs_intr_t next_intr_st;
	assign next_intr_st = !deb[3] ? fprs_pkg::INTR_INIT :
		!deb[2] ? fprs_pkg::INTR_ACTIVE : fprs_pkg::INTR_NORMAL;

	always_ff @(posedge clk) begin
		if (core_rst) begin
			intr_st       <= fprs_pkg::INTR_NORMAL;
			fan_level_out <= 8'h00;
		end else begin
			intr_st       <= next_intr_st;
			fan_level_out <= (intr_st == fprs_pkg::INTR_ACTIVE) ?
				`FPRS_FAN_BOOST : fan_level_in;
		end
	end

	// Severity ignores the watchdog entirely, so its expiry cannot move the LED.
	fprs_pkg::fprs_led_t led_st;
	fprs_pkg::fprs_led_t next_led_st;
	assign next_led_st = faults.fatal ? fprs_pkg::LED_FATAL :
		faults.nonfatal ? fprs_pkg::LED_NONFATAL :
		faults.degraded ? fprs_pkg::LED_DEGRADED :
		faults.ready ? fprs_pkg::LED_OK : fprs_pkg::LED_OFF;

	logic [26:0] blink_cnt;
	logic        blink_ph;
	always_ff @(posedge clk) begin
		if (core_rst) begin
			led_st    <= fprs_pkg::LED_OFF;
			blink_cnt <= 27'h000_0000;
			blink_ph  <= 1'b0;
			led_green <= 1'b0;
			led_amber <= 1'b0;
		end else begin
			if (pg_s) begin
				led_st <= next_led_st;
			end
			if (blink_cnt == 27'(BLINK_CYC - 1)) begin
				blink_cnt <= 27'h000_0000;
				blink_ph  <= ~blink_ph;
			end else begin
				blink_cnt <= blink_cnt + 27'h000_0001;
			end
			led_green <= (led_st == fprs_pkg::LED_OK) |
				((led_st == fprs_pkg::LED_DEGRADED) & blink_ph);
			led_amber <= (led_st == fprs_pkg::LED_FATAL) |
				((led_st == fprs_pkg::LED_NONFATAL) & blink_ph);
		end
	end

	// Port 80h capture never stalls the host; a full FIFO sheds its oldest code.
	logic [7:0]  fifo_mem [DEPTH];
	logic [2:0]  fifo_wp;
	logic [2:0]  fifo_rp;
	logic [3:0]  fifo_cnt;
	logic [26:0] hold_cnt;
	wire fifo_full = (fifo_cnt == 4'(DEPTH));
	wire hold_done = (hold_cnt == 27'(POST_HOLD_CYC - 1));
	wire fifo_pop  = hold_done & (fifo_cnt != 4'h0);
	wire rp_step   = fifo_pop | (port80_wr & fifo_full);

	always_ff @(posedge clk) begin
		if (port80_wr) begin
			fifo_mem[fifo_wp] <= port80_data;
		end
	end

	always_ff @(posedge clk) begin
		if (core_rst) begin
			fifo_wp  <= 3'h0;
			fifo_rp  <= 3'h0;
			fifo_cnt <= 4'h0;
			hold_cnt <= 27'h000_0000;
			post_led <= 8'h00;
		end else begin
			hold_cnt <= hold_done ? 27'h000_0000 : hold_cnt + 27'h000_0001;
			if (port80_wr) begin
				fifo_wp <= fifo_wp + 3'h1;
			end
			if (rp_step) begin
				fifo_rp <= fifo_rp + 3'h1;
			end
			if (port80_wr & ~rp_step) begin
				fifo_cnt <= fifo_cnt + 4'h1;
			end else if (~port80_wr & fifo_pop) begin
				fifo_cnt <= fifo_cnt - 4'h1;
			end
			if (fifo_pop) begin
				post_led <= fifo_mem[fifo_rp];
			end
		end
	end

	wire [31:0] status_word = {16'h0000, fifo_cnt, led_st, chipset_rst_n, pg_s,
		~post_s, intr_st, ~deb[2], ~deb[1], ~deb[0], lock};
	wire [31:0] rd_mux =
		hit(reg_addr, `FPRS_ADDR_CTRL)   ? {24'h00_0000, ctrl} :
		hit(reg_addr, `FPRS_ADDR_STATUS) ? status_word :
		hit(reg_addr, `FPRS_ADDR_EVENT)  ? {27'h000_0000, evt_flags} :
		hit(reg_addr, `FPRS_ADDR_REASON) ? {30'h0000_0000, reason} :
		hit(reg_addr, `FPRS_ADDR_POST)   ? {24'h00_0000, post_led} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (core_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (core_rst);

	sequence press_held_s;
		!chipset_rst_n [*8];
	endsequence

	sequence locked_press_s;
		rst_press && lock && !cmd_rst && !wdog_rst && !pef_rst &&
			press_st == fprs_pkg::PRESS_IDLE;
	endsequence

	rst_debounce_a: assert property ($changed(deb[0]) |->
		$past(deb_cnt[0]) == 27'(RST_DEB_CYC - 1))
		else $error("reset button changed before its debounce time");
	pwr_debounce_a: assert property ($changed(deb[1]) |->
		$past(deb_cnt[1]) == 27'(FP_DEB_CYC - 1))
		else $error("power button changed before its debounce time");
	lock_block_a: assert property (locked_press_s |=>
		events.sec_violation && $stable(press_st))
		else $error("locked press was not turned into a violation");
	press_pulse_a: assert property (press_go |=> press_held_s)
		else $error("emulated reset press too short");
	host_reset_a: assert property (post_rise |=> sia_start && events.host_reset)
		else $error("host reset did not start the init agent");
	wdog_reset_a: assert property (wdog_expire && ctrl[`FPRS_CTRL_ACT_RST] && armed &&
		press_st == fprs_pkg::PRESS_IDLE |=> !chipset_rst_n)
		else $error("watchdog expiry did not reset the host");
	reason_keep_a: assert property (reason[`FPRS_RSN_BOOT] && !rsn_clr |=>
		reason[`FPRS_RSN_BOOT])
		else $error("timeout reason bit lost");
	fatal_led_a: assert property (faults.fatal && pg_s |=> ##1 led_amber && !led_green)
		else $error("fatal fault not shown as solid amber");
	intr_event_a: assert property (intr_chg |=> events.intrusion &&
		evt_offset == `FPRS_INTR_OFFSET)
		else $error("intrusion change produced no event");
	fan_boost_a: assert property (intr_st == fprs_pkg::INTR_ACTIVE |=>
		fan_level_out == `FPRS_FAN_BOOST)
		else $error("fans not boosted during intrusion");
	cable_init_a: assert property (cable_lost |=>
		intr_st == fprs_pkg::INTR_INIT && events.cable_missing)
		else $error("missing cable not reported");
	post_drop_a: assert property (fifo_full && port80_wr |=> fifo_full)
		else $error("overflowing write changed the fill level");
endmodule

// ### testbench/fprs_panel.sv
// Behavioural front panel switches, chassis sense lines and host chipset for the supervisor.
`timescale 1ns/1ps
`include "fprs_map.svh"
module fprs_panel (
	input  wire logic clk,
	output logic [5:0] pins,
	output logic       wdog_expire,
	output logic       port80_wr,
	output logic [7:0] port80_data
);
	// Pin order: reset, power, intrusion, cable, post_complete_n, power good.
	initial begin
		pins = `FPRS_PIN_IDLE;
		wdog_expire = 1'b0;
		port80_wr = 1'b0;
		port80_data = 8'h00;
	end
	task automatic set(input int i, input logic v);
		@(posedge clk);
		pins[i] <= v;
	endtask
	// Boot firmware lets the boot timer expire only inside POST, never at a password prompt.
	task automatic expire();
		@(posedge clk);
		wdog_expire <= 1'b1;
		@(posedge clk);
		wdog_expire <= 1'b0;
	endtask
	// Port 80h writes arrive one per cycle; the host never waits for the display.
	task automatic post(input logic [7:0] d);
		@(posedge clk);
		port80_wr <= 1'b1;
		port80_data <= d;
	endtask
	// Released data is inverted so a stale value cannot pass for a fresh one.
	task automatic post_end();
		@(posedge clk);
		port80_wr <= 1'b0;
		port80_data <= ~port80_data;
	endtask
endmodule

// ### testbench/fprs_supervisor_tb.sv
// Self-checking bench for the front panel and system reset supervisor.
`timescale 1ns/1ps
`include "fprs_map.svh"
module fprs_supervisor_tb;
	localparam int RST_DEB = 20;
	localparam int FP_DEB  = 10;
	localparam int PRESS   = 16;
	logic                  clk;
	logic                  sys_rst;
	logic [7:0]            reg_addr;
	logic [31:0]           reg_wdata;
	logic                  reg_wr;
	logic                  reg_rd;
	logic [31:0]           reg_rdata;
	logic [5:0]            pins;
	logic                  fw_update_done;
	logic                  wdog_expire;
	logic                  port80_wr;
	logic [7:0]            port80_data;
	fprs_pkg::fprs_fault_t faults;
	logic [7:0]            fan_in;
	logic                  chipset_rst_n;
	logic                  led_green;
	logic                  led_amber;
	logic [7:0]            fan_out;
	logic [7:0]            post_led;
	fprs_pkg::fprs_evt_t   events;
	logic [7:0]            evt_offset;
	logic                  sia_start;
	int                    failures;
	int                    samples_checked;
	int                    n_sec, n_intr, n_cab, n_wdf, n_host, n_sia, n_low, g, a;
	logic [7:0]            seed;
	logic [31:0]           rd;
	logic [3:0]            ftab [7] = '{4'h1, 4'h3, 4'h7, 4'hF, 4'h0, 4'h8, 4'h5};

	fprs_panel fprs_panel_inst (
		.clk         (clk),
		.pins        (pins),
		.wdog_expire (wdog_expire),
		.port80_wr   (port80_wr),
		.port80_data (port80_data)
	);
	fprs_supervisor #(.RST_DEB_CYC(RST_DEB), .FP_DEB_CYC(FP_DEB), .PRESS_CYC(PRESS),
		.BLINK_CYC(8), .POST_HOLD_CYC(4)) fprs_supervisor_inst (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_wr          (reg_wr),
		.reg_rd          (reg_rd),
		.reg_rdata       (reg_rdata),
		.reset_btn_n     (pins[0]),
		.power_btn_n     (pins[1]),
		.intrusion_n     (pins[2]),
		.intr_cable_ok   (pins[3]),
		.post_complete_n (pins[4]),
		.main_pwr_good   (pins[5]),
		.fw_update_done  (fw_update_done),
		.wdog_expire     (wdog_expire),
		.port80_wr       (port80_wr),
		.port80_data     (port80_data),
		.faults          (faults),
		.fan_level_in    (fan_in),
		.chipset_rst_n   (chipset_rst_n),
		.led_green       (led_green),
		.led_amber       (led_amber),
		.fan_level_out   (fan_out),
		.post_led        (post_led),
		.events          (events),
		.evt_offset      (evt_offset),
		.sia_start       (sia_start)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		n_sec += events.sec_violation;
		n_intr += events.intrusion;
		n_cab += events.cable_missing;
		n_wdf += events.wdog_boot_fail;
		n_host += events.host_reset;
		n_sia += sia_start;
		n_low += !chipset_rst_n;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Expected pattern per colour: 0 dark, 1 solid, 2 blinking; the worst fault wins.
	function automatic int led_kind(input logic [3:0] f, input logic amber);
		if (f[3]) return amber ? 1 : 0;
		if (f[2]) return amber ? 2 : 0;
		if (f[1]) return amber ? 0 : 2;
		if (f[0]) return amber ? 0 : 1;
		return 0;
	endfunction
	function automatic int seen_kind(input int n);
		return (n == 0) ? 0 : (n == 24) ? 1 : 2;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic clr();
		{n_sec, n_intr, n_cab, n_wdf, n_host, n_sia, n_low} = '0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] ad);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
	endtask
	task automatic led_watch();
		g = 0;
		a = 0;
		repeat (24) begin
			cyc(1);
			g += led_green;
			a += led_amber;
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	initial begin
		{sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd, fw_update_done} = '1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, fw_update_done} = '0;
		faults = 4'h0;
		fan_in = 8'h00;
		seed = 8'h39;
		{failures, samples_checked} = '0;
		clr();
		repeat (2) @(posedge clk);
		fprs_panel_inst.set(4, 1'b0);
		fprs_panel_inst.set(5, 1'b1);
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(30);
		clr();
		rdr(`FPRS_ADDR_CTRL);
		chk(rd, 32'h0000_0000, "ctrl reset");
		rdr(8'h20);
		chk(rd, 32'h0000_0000, "unmapped read");
		rdr(`FPRS_ADDR_REASON);
		chk(rd, 32'h0000_0000, "reason reset");
		$display("test registers done");
		// A press one cycle shorter than the window must be ignored entirely.
		fprs_panel_inst.set(0, 1'b0);
		cyc(RST_DEB - 2);
		fprs_panel_inst.set(0, 1'b1);
		cyc(40);
		chk(n_low, 0, "glitch press");
		fprs_panel_inst.set(0, 1'b0);
		cyc(RST_DEB + 10);
		fprs_panel_inst.set(0, 1'b1);
		cyc(PRESS + RST_DEB + 10);
		chk(n_low, PRESS, "button press width");
		$display("test button done");
		wr(`FPRS_ADDR_CTRL, 32'h0000_0001);
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[0], 1'b1, "lockout status");
		clr();
		fprs_panel_inst.set(0, 1'b0);
		cyc(RST_DEB + 10);
		fprs_panel_inst.set(0, 1'b1);
		cyc(RST_DEB + 10);
		chk(n_low, 0, "locked press");
		chk(n_sec, 1, "violation event");
		rdr(`FPRS_ADDR_EVENT);
		chk(rd, 32'h0000_0010, "event flag");
		wr(`FPRS_ADDR_EVENT, 32'h0000_001F);
		rdr(`FPRS_ADDR_EVENT);
		chk(rd, 32'h0000_0000, "event clear");
		$display("test lockout done");
		clr();
		wr(`FPRS_ADDR_CTRL, 32'h0000_0002);
		wr(`FPRS_ADDR_CTRL, 32'h0000_0002);
		cyc(PRESS + 5);
		chk(n_low, PRESS, "command press");
		rdr(`FPRS_ADDR_CTRL);
		chk(rd[1], 1'b0, "command bit");
		clr();
		wr(`FPRS_ADDR_CTRL, 32'h0000_0100);
		cyc(PRESS);
		chk(n_low, 0, "filter action disabled");
		wr(`FPRS_ADDR_CTRL, 32'h0000_0010);
		wr(`FPRS_ADDR_CTRL, 32'h0000_0110);
		cyc(PRESS + 5);
		chk(n_low, PRESS, "filter action press");
		$display("test command done");
		clr();
		fprs_panel_inst.set(4, 1'b1);
		cyc(8);
		chk(n_host, 1, "host reset seen");
		chk(n_sia, 1, "init agent start");
		chk(n_low, 0, "no participation");
		fprs_panel_inst.set(4, 1'b0);
		$display("test host reset done");
		@(posedge clk);
		faults <= 4'h1;
		cyc(5);
		clr();
		wr(`FPRS_ADDR_CTRL, 32'h0000_002C);
		fprs_panel_inst.expire();
		cyc(PRESS + 5);
		chk(n_wdf, 1, "boot fail event");
		chk(n_low, PRESS, "watchdog press");
		rdr(`FPRS_ADDR_CTRL);
		chk(rd, 32'h0000_002C, "ctrl after expiry");
		led_watch();
		chk(seen_kind(g), 1, "led kept");
		wr(`FPRS_ADDR_CTRL, 32'h0000_0000);
		fprs_panel_inst.expire();
		cyc(4);
		rdr(`FPRS_ADDR_REASON);
		chk(rd[1:0], 2'b11, "reason bits");
		chk(n_wdf, 1, "other use silent");
		@(posedge clk);
		fw_update_done <= 1'b1;
		@(posedge clk);
		fw_update_done <= 1'b0;
		cyc(10);
		rdr(`FPRS_ADDR_REASON);
		chk(rd[1:0], 2'b11, "reason after update");
		rdr(`FPRS_ADDR_CTRL);
		chk(rd, 32'h0000_0000, "ctrl after update");
		chk(n_host, 0, "state adopted");
		wr(`FPRS_ADDR_REASON, 32'h0000_0001);
		rdr(`FPRS_ADDR_REASON);
		chk(rd, 32'h0000_0002, "reason clear");
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		cyc(30);
		rdr(`FPRS_ADDR_REASON);
		chk(rd, 32'h0000_0000, "reason after ac loss");
		$display("test watchdog done");
		foreach (ftab[i]) begin
			@(posedge clk);
			faults <= ftab[i];
			cyc(4);
			led_watch();
			chk(seen_kind(g), led_kind(ftab[i], 1'b0), "green pattern");
			chk(seen_kind(a), led_kind(ftab[i], 1'b1), "amber pattern");
		end
		@(posedge clk);
		faults <= 4'h8;
		cyc(4);
		fprs_panel_inst.set(5, 1'b0);
		cyc(10);
		@(posedge clk);
		faults <= 4'h0;
		led_watch();
		chk(seen_kind(a), 1, "led retained");
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[11:9], 3'h4, "led state held");
		$display("test led done");
		clr();
		fprs_panel_inst.set(2, 1'b0);
		cyc(FP_DEB + 8);
		chk(n_intr, 1, "intrusion in standby");
		chk(evt_offset, 8'h00, "intrusion offset");
		chk(fan_out, `FPRS_FAN_BOOST, "fan boost");
		seed = lfsr(seed);
		@(posedge clk);
		fan_in <= seed;
		fprs_panel_inst.set(2, 1'b1);
		cyc(FP_DEB + 8);
		chk(n_intr, 2, "intrusion cleared");
		chk(fan_out, seed, "fan restored");
		fprs_panel_inst.set(5, 1'b1);
		fprs_panel_inst.set(3, 1'b0);
		cyc(FP_DEB + 8);
		chk(n_cab, 1, "cable event");
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[5:4], 2'b10, "init in progress");
		fprs_panel_inst.set(3, 1'b1);
		$display("test intrusion done");
		fprs_panel_inst.set(1, 1'b0);
		cyc(4);
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[2], 1'b0, "power early");
		cyc(FP_DEB);
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[2], 1'b1, "power held");
		fprs_panel_inst.set(1, 1'b1);
		$display("test power button done");
		fprs_panel_inst.post(8'hA5);
		fprs_panel_inst.post_end();
		cyc(12);
		chk(post_led, 8'hA5, "single code");
		rdr(`FPRS_ADDR_POST);
		chk(rd, 32'h0000_00A5, "post register");
		repeat (12) begin
			seed = lfsr(seed);
			fprs_panel_inst.post(seed);
		end
		fprs_panel_inst.post_end();
		cyc(60);
		chk(post_led, seed, "burst last code");
		rdr(`FPRS_ADDR_STATUS);
		chk(rd[15:12], 4'h0, "fifo drained");
		$display("test post codes done");
		results();
	end
endmodule
